// ### rtl/cibw_defines.svh
// Constants for the channel input buffer memory write path.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef CIBW_DEFINES_SVH
`define CIBW_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CIBW_WORD_W 72
`define CIBW_LANE_W 9
`define CIBW_XFERS 4
`define CIBW_DATA_W 32
`define CIBW_CHK_W 8
`define CIBW_ADDR_W 16
`define CIBW_SEL_N 8
`define CIBW_FIFO_DEPTH 16

// ----------------------------------------
// Sync phases
// ----------------------------------------
`define CIBW_PHASE_LAST 3'h5
`define CIBW_PH_REF 3'h0
`define CIBW_PH_LOAD 3'h2
`define CIBW_PH_WRITE 3'h3
`define CIBW_PH_BSEL 3'h4
`define CIBW_PH_READ 3'h5
`define CIBW_ONBOARD_MAX 3'h3

`endif

// ### rtl/cibw_pkg.sv
// Types shared by the write path, its checker and its bench.
// Assumes cibw_defines.svh is reachable by bare name.
`include "cibw_defines.svh"
package cibw_pkg;
   typedef logic [2:0] cibw_phase_t;
   typedef struct packed {
      logic [`CIBW_WORD_W-1:0] data;
      logic [`CIBW_ADDR_W-1:0] addr;
   } cibw_word_t;
   typedef struct packed {
      logic [2:0] chan;
      logic b_select;
   } cibw_param_t;
   typedef struct packed {
      logic [`CIBW_DATA_W-1:0] data;
      logic [`CIBW_CHK_W-1:0] check;
      logic [`CIBW_ADDR_W-1:0] addr;
      logic write_enable;
      logic drive;
   } cibw_mem_t;
   typedef enum {CIBW_IDLE, CIBW_SEND, CIBW_WAIT} cibw_state_t;
endpackage

// ### rtl/cibw_fifo.sv
// Flip-flop FIFO carrying words into the write path.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ns
module cibw_fifo #(
   parameter int WIDTH = 88,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; empty flag guards stale words
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ### rtl/cibw_write_path.sv
// Channel input buffer memory write path: buffer slice, check-bit and
// data memory slices. Assumes the sync pulse every sixth clock and an
// input control slice that supplies words, parameters and addresses.
// Limitation: one word per two sync cycles, since the fanin transfers
// fill one cycle and the memory write needs the next.
`timescale 1ns/1ns
`include "cibw_defines.svh"
module cibw_write_path
   import cibw_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sync_pulse,
   input wire logic word_valid,
   output logic word_ready,
   input wire cibw_pkg::cibw_word_t word_in,
   input wire cibw_pkg::cibw_param_t param_in,
   input wire logic [4:0] buf_write_addr,
   input wire logic [4:0] buf_read_addr,
   input wire logic buf_write,
   output logic [`CIBW_LANE_W-1:0] fanin_lane,
   output logic fanin_strobe,
   output logic [`CIBW_SEL_N-1:0] channel_select_outputs,
   output logic onboard_select_input,
   output logic offboard_select_input,
   output logic write_reference,
   output logic b_pointer,
   output logic read_reference,
   output cibw_pkg::cibw_mem_t mem_out,
   output logic [2:0] raw_write_enable,
   output logic final_write_enable
);
   import cibw_pkg::*;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [`CIBW_SEL_N-1:0] sel_decode(input logic [2:0] ch);
      sel_decode = 8'h01 << ch;
   endfunction

   function automatic logic [`CIBW_LANE_W-1:0] lane_of(input logic [`CIBW_WORD_W-1:0] w,
                                                      input logic [1:0] idx);
      lane_of = w[idx*`CIBW_LANE_W*2 +: `CIBW_LANE_W];
   endfunction

   // ----------------------------------------
   // Sync phase counter
   // ----------------------------------------
   cibw_phase_t phase, next_phase;
   always_comb begin
      if (sync_pulse) begin
         next_phase = 3'h0;
      end else if (phase == `CIBW_PHASE_LAST) begin
         next_phase = 3'h0;
      end else begin
         next_phase = phase + 3'h1;
      end
   end
   // Counter free-runs between pulses and wraps after phase five, so a missed pulse keeps the frame
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase <= 3'h0;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------
   // Input FIFO
   // ----------------------------------------
   logic f_valid, f_ready;
   cibw_word_t f_word;
   // Sixteen words absorb bursts while the buffer addresses match
   cibw_fifo #(
      .WIDTH($bits(cibw_word_t)),
      .DEPTH(`CIBW_FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(word_valid),
      .in_ready(word_ready),
      .in_data(word_in),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_word)
   );

   // ----------------------------------------
   // Buffer slice
   // ----------------------------------------
   cibw_state_t state, next_state;
   cibw_word_t held, next_held;
   cibw_param_t param, next_param;
   logic [1:0] xfer, next_xfer;
   logic collide_hold, next_collide_hold;
   logic ref_go;
   logic [`CIBW_SEL_N-1:0] sel, next_sel;
   logic [`CIBW_LANE_W-1:0] next_lane;
   logic next_strobe;

   logic addr_differ;
   assign addr_differ = (buf_write_addr != buf_read_addr);
   // Reference issued only when buffer addresses differ
   assign ref_go = (phase == `CIBW_PH_REF) && addr_differ && f_valid;
   // A take that meets a buffer write goes one clock later, at phase one
   assign f_ready = (state == CIBW_IDLE) && f_valid && addr_differ
      && ((ref_go && !buf_write) || collide_hold);

   always_comb begin
      next_state = state;
      next_held = held;
      next_param = param;
      next_xfer = xfer;
      next_lane = fanin_lane;
      next_strobe = 1'b0;
      next_sel = sel;
      // Write landing on the read cycle pushes the read out a clock
      next_collide_hold = buf_write && ref_go && (state == CIBW_IDLE);
      if (phase == `CIBW_PH_READ) begin
         next_sel = '0;
      end
      case (state)
         CIBW_IDLE: begin
            if (f_ready) begin
               next_held = f_word;
               next_param = param_in;
               next_xfer = 2'h0;
               next_state = CIBW_SEND;
            end
         end
         CIBW_SEND: begin
            // Lane k carries bits 18k up to 18k+8 of the stored word
            next_lane = lane_of(held.data, xfer);
            next_strobe = 1'b1;
            next_xfer = xfer + 2'h1;
            if (xfer == 2'h3) begin
               next_state = CIBW_WAIT;
            end
         end
         CIBW_WAIT: begin
            // Select waits a frame, so all four bytes are in before phase three
            if (phase == `CIBW_PH_LOAD && sel == '0) begin
               next_sel = sel_decode(param.chan);
            end else if (phase == `CIBW_PHASE_LAST && sel != '0) begin
               next_state = CIBW_IDLE;
            end
         end
         default: next_state = CIBW_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= CIBW_IDLE;
         held <= '0;
         param <= '0;
         xfer <= 2'h0;
         collide_hold <= 1'b0;
         sel <= '0;
         fanin_lane <= '0;
         fanin_strobe <= 1'b0;
      end else begin
         state <= next_state;
         held <= next_held;
         param <= next_param;
         xfer <= next_xfer;
         collide_hold <= next_collide_hold;
         sel <= next_sel;
         fanin_lane <= next_lane;
         fanin_strobe <= next_strobe;
      end
   end

   // ----------------------------------------
   // Select presentation
   // ----------------------------------------
   // Select lines carry meaning by phase; B only shown at phase four
   always_comb begin
      channel_select_outputs = '0;
      if (phase == `CIBW_PH_WRITE || phase == `CIBW_PH_READ) begin
         channel_select_outputs = sel;
      end else if (phase == `CIBW_PH_BSEL && param.b_select) begin
         channel_select_outputs = sel;
      end
   end
   // ----------------------------------------
   // Phase decodes
   // ----------------------------------------
   assign onboard_select_input = |channel_select_outputs[3:0];
   assign offboard_select_input = |channel_select_outputs[7:4];
   logic any_sel;
   assign any_sel = onboard_select_input || offboard_select_input;
   assign write_reference = any_sel && (phase == `CIBW_PH_WRITE);
   assign b_pointer = any_sel && (phase == `CIBW_PH_BSEL);
   assign read_reference = any_sel && (phase == `CIBW_PH_READ);

   // ----------------------------------------
   // Check-bit and data memory slices
   // ----------------------------------------
   logic [`CIBW_DATA_W-1:0] dat, next_dat;
   logic [`CIBW_CHK_W-1:0] chk, next_chk;
   logic [`CIBW_ADDR_W-1:0] adr, next_adr;
   logic [1:0] byte_cnt, next_byte_cnt;
   logic capturing, next_capturing;
   logic [2:0] next_raw;
   cibw_mem_t next_mem;

   always_comb begin
      next_dat = dat;
      next_chk = chk;
      next_adr = adr;
      next_byte_cnt = byte_cnt;
      next_capturing = capturing;
      if (state == CIBW_IDLE && f_ready) begin
         next_capturing = 1'b1;
         next_byte_cnt = 2'h0;
         next_adr = f_word.addr;
      end
      if (fanin_strobe && capturing) begin
         // Low eight lane bits are data, the ninth is a check bit
         next_dat[byte_cnt*8 +: 8] = fanin_lane[7:0];
         // Fanin check bits are kept until the stored ones replace them
         next_chk[byte_cnt*2 +: 2] = {fanin_lane[8], fanin_lane[8]};
         next_byte_cnt = byte_cnt + 2'h1;
         if (byte_cnt == 2'h3) begin
            next_capturing = 1'b0;
         end
      end
      // Latched as the select rises, so phase three already drives them
      if (next_phase == `CIBW_PH_WRITE && next_sel != '0) begin
         next_chk = held.data[`CIBW_WORD_W-1 -: `CIBW_CHK_W];
      end
   end

   // ----------------------------------------
   // Write enable and memory word
   // ----------------------------------------
   // Raw pulse: bit 0 write pulse, bits 1 and 2 the two clock pulses
   always_comb begin
      next_raw = 3'h0;
      if (write_reference) begin
         next_raw = 3'h7;
      end else if (raw_write_enable[0] && phase == `CIBW_PH_BSEL) begin
         next_raw = 3'h6;
      end
      next_mem = '0;
      // Word goes out with the select, held steady through phase five
      if (next_phase >= `CIBW_PH_WRITE && next_sel != '0) begin
         next_mem.drive = 1'b1;
         next_mem.data = next_dat;
         next_mem.check = next_chk;
         next_mem.addr = next_adr;
      end
      // Pulse only where the fed-back pulse and both clocks agree
      next_mem.write_enable = raw_write_enable[0] && raw_write_enable[2] && next_raw[1];
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dat <= '0;
         chk <= '0;
         adr <= '0;
         byte_cnt <= 2'h0;
         capturing <= 1'b0;
         raw_write_enable <= 3'h0;
         mem_out <= '0;
      end else begin
         dat <= next_dat;
         chk <= next_chk;
         adr <= next_adr;
         byte_cnt <= next_byte_cnt;
         capturing <= next_capturing;
         raw_write_enable <= next_raw;
         mem_out <= next_mem;
      end
   end

   // Final enable leaves the same flip-flop as the word it writes
   assign final_write_enable = mem_out.write_enable;
endmodule

// ### sim/cibw_asserts.sv
// Port checker for the write path.
// Assumes the design's top ports and one clock domain.
`timescale 1ns/1ns
module cibw_asserts
   import cibw_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sync_pulse,
   input wire logic [4:0] buf_write_addr,
   input wire logic [4:0] buf_read_addr,
   input wire logic buf_write,
   input wire logic fanin_strobe,
   input wire logic [7:0] channel_select_outputs,
   input wire logic onboard_select_input,
   input wire logic offboard_select_input,
   input wire logic write_reference,
   input wire logic b_pointer,
   input wire logic read_reference,
   input wire cibw_pkg::cibw_mem_t mem_out,
   input wire logic [2:0] raw_write_enable,
   input wire logic final_write_enable
);
   // ----------------
   // Phase tracker
   // ----------------
   logic [2:0] ph;
   logic [2:0] next_ph;
   always_comb begin
      next_ph = (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (sync_pulse) begin
         next_ph = 3'h0;
      end
   end
   always_ff @(posedge core_clk) begin
      ph <= rst ? 3'h0 : next_ph;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_burst;
      fanin_strobe [*3] ##1 !fanin_strobe;
   endsequence
   sequence s_hold;
      (mem_out.drive && $stable(mem_out.data) && $stable(mem_out.addr)) [*2];
   endsequence
   AST_BURST: assert property ($rose(fanin_strobe) |=> s_burst)
      else $error("fanin burst is not four transfers");
   AST_TAKE: assert property ($rose(fanin_strobe) |->
      $past(buf_write_addr, 2) != $past(buf_read_addr, 2))
      else $error("word taken with equal buffer addresses");
   // A take at phase zero never meets a buffer write; a collided one moves to phase one
   AST_COLLIDE: assert property ($rose(fanin_strobe) |->
      ($past(ph, 2) == 3'h0 && !$past(buf_write, 2))
      || ($past(ph, 2) == 3'h1 && $past(buf_write, 3)))
      else $error("buffer write collision not delayed one clock");
   AST_ONEHOT: assert property ($onehot0(channel_select_outputs))
      else $error("more than one channel select");
   AST_SIDE: assert property (onboard_select_input == (|channel_select_outputs[3:0])
      && offboard_select_input == (|channel_select_outputs[7:4]))
      else $error("onboard or offboard select wrong");
   AST_DECODE: assert property ((write_reference |-> ph == 3'h3)
      and (b_pointer |-> ph == 3'h4) and (read_reference |-> ph == 3'h5))
      else $error("select decoded in wrong phase");
   AST_DRIVE: assert property (mem_out.drive |-> ph >= 3'h3)
      else $error("memory driven outside phases three to five");
   AST_HOLD: assert property ($rose(mem_out.drive) |=> s_hold)
      else $error("memory data or address not held");
   AST_WE_START: assert property (write_reference |-> ##[0:1] raw_write_enable != 3'h0)
      else $error("write enable not started");
   AST_FINAL: assert property (final_write_enable |-> mem_out.drive && mem_out.write_enable)
      else $error("final write enable without driven word");
endmodule
bind cibw_write_path cibw_asserts i_cibw_asserts (.core_clk(core_clk), .rst(rst),
   .sync_pulse(sync_pulse), .buf_write_addr(buf_write_addr), .buf_read_addr(buf_read_addr),
   .buf_write(buf_write),
   .fanin_strobe(fanin_strobe), .channel_select_outputs(channel_select_outputs),
   .onboard_select_input(onboard_select_input), .offboard_select_input(offboard_select_input),
   .write_reference(write_reference), .b_pointer(b_pointer), .read_reference(read_reference),
   .mem_out(mem_out), .raw_write_enable(raw_write_enable),
   .final_write_enable(final_write_enable));

// ### sim/cibw_far_side.sv
// Input control slice stand-in: sync pulse, buffer addresses, collisions.
// Assumes the bench raises hold to make the buffer look empty.
`timescale 1ns/1ns
module cibw_far_side (
   input wire logic core_clk,
   input wire logic hold,
   output logic sync_pulse,
   output logic [4:0] buf_write_addr,
   output logic [4:0] buf_read_addr,
   output logic buf_write
);
   int cnt = 0;
   int seed = 63762;
   initial begin
      sync_pulse = 0;
      buf_write_addr = 5'h00;
      buf_read_addr = 5'h00;
      buf_write = 0;
   end
   always @(negedge core_clk) begin
      cnt <= (cnt == 5) ? 0 : cnt + 1;
      sync_pulse <= (cnt == 5);
      buf_write_addr <= buf_write_addr + 5'(cnt == 5);
      buf_read_addr <= hold ? buf_write_addr : buf_write_addr + 5'h01;
      buf_write <= ($random(seed) % 4) == 0;
   end
endmodule

// ### sim/cibw_write_path_test.sv
// Self-checking bench for the write path with a queue model.
// Assumes the checker is bound and the far side model drives sync.
`timescale 1ns/1ns
module cibw_write_path_test;
   import cibw_pkg::*;
   typedef struct {cibw_word_t w; cibw_param_t p;} cibw_exp_t;
   logic core_clk = 0;
   logic rst = 1;
   logic word_valid = 0;
   logic hold = 0;
   logic b_chk = 0;
   logic seen_we = 0;
   cibw_word_t word_in = '0;
   cibw_param_t param_in = '0;
   logic sync_pulse, word_ready, buf_write, fanin_strobe, onboard, offboard;
   logic write_reference, b_pointer, read_reference, final_write_enable;
   logic [4:0] buf_write_addr, buf_read_addr;
   logic [8:0] fanin_lane;
   logic [7:0] sel;
   logic [2:0] raw;
   cibw_mem_t mem_out;
   cibw_exp_t exp_q[$];
   cibw_exp_t e;
   int errors = 0;
   int total_checks = 0;
   int li = 0;
   int wi = 0;
   int seed = 63762;
   always #10 core_clk = ~core_clk;
   cibw_far_side i_cibw_far_side (.core_clk(core_clk), .hold(hold), .sync_pulse(sync_pulse),
      .buf_write_addr(buf_write_addr), .buf_read_addr(buf_read_addr), .buf_write(buf_write));
   cibw_write_path i_cibw_write_path (.core_clk(core_clk), .rst(rst), .sync_pulse(sync_pulse),
      .word_valid(word_valid), .word_ready(word_ready), .word_in(word_in), .param_in(param_in),
      .buf_write_addr(buf_write_addr), .buf_read_addr(buf_read_addr), .buf_write(buf_write),
      .fanin_lane(fanin_lane), .fanin_strobe(fanin_strobe), .channel_select_outputs(sel),
      .onboard_select_input(onboard), .offboard_select_input(offboard),
      .write_reference(write_reference), .b_pointer(b_pointer), .read_reference(read_reference),
      .mem_out(mem_out), .raw_write_enable(raw), .final_write_enable(final_write_enable));
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task finish_test;
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [31:0] bytes_of(input cibw_word_t w);
      for (int k = 0; k < 4; k++) begin
         bytes_of[8*k +: 8] = w.data[18*k +: 8];
      end
   endfunction
   // ----------------
   // Model compare
   // ----------------
   always @(posedge core_clk) begin
      if (wi < exp_q.size()) e = exp_q[wi];
      if (!rst && fanin_strobe) begin
         check("lane", 32'(exp_q[li/4].w.data[18*(li%4) +: 9]), 32'(fanin_lane));
         li++;
      end
      if (!rst && final_write_enable) seen_we = 1;
      if (b_chk) check("b_pointer", 32'(e.p.b_select), 32'(b_pointer));
      b_chk = !rst && write_reference;
      if (b_chk) check("select", 32'(8'h01 << e.p.chan), 32'(sel));
      if (b_chk) check("onboard", 32'(e.p.chan < 3'h4), 32'(onboard));
      if (b_chk) check("offboard", 32'(e.p.chan >= 3'h4), 32'(offboard));
      if (b_chk) check("data_w", bytes_of(e.w), mem_out.data);
      if (!rst && read_reference) begin
         check("data", bytes_of(e.w), mem_out.data);
         check("check", 32'(e.w.data[71:64]), 32'(mem_out.check));
         check("addr", 32'(e.w.addr), 32'(mem_out.addr));
         check("drive", 32'h0000_0001, 32'(mem_out.drive));
         check("write_enable", 32'h0000_0001, 32'(seen_we));
         seen_we = 0;
         wi++;
      end
   end
   task push(input int n, input cibw_param_t p);
      for (int i = 0; i < n; i++) begin
         word_in = 88'({$random(seed), $random(seed), $random(seed)});
         param_in = p;
         word_valid = 1;
         do @(posedge core_clk); while (word_ready !== 1'b1);
         exp_q.push_back('{word_in, p});
         @(negedge core_clk);
      end
      word_valid = 0;
   endtask
   task drain;
      for (int t = 0; t < 900 && wi < exp_q.size(); t++) @(negedge core_clk);
      check("written", exp_q.size(), wi);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 0;
      for (int c = 0; c < 8; c++) begin
         push(c % 3 + 1, '{3'(c), 1'($random(seed))});
         drain();
      end
      hold = 1;
      repeat (7) @(negedge core_clk);
      push(16, '{3'h5, 1'b1});
      @(posedge core_clk);
      check("fifo_ready", 32'h0000_0000, 32'(word_ready));
      check("no_take", exp_q.size() * 4 - 64, li);
      @(negedge core_clk);
      hold = 0;
      drain();
      finish_test();
   end
   initial begin
      #(20 * 8000);
      errors++;
      finish_test();
   end
endmodule
